/* File: src/mfh_consts.svh */
// Constants for the FIFO threshold, soft reset, station address and
// group hash register slice. Assumes inclusion by bare name.
`ifndef MFH_CONSTS_SVH
`define MFH_CONSTS_SVH
// -----------------------------------------------------------------
// Register byte addresses
// -----------------------------------------------------------------
`define MFH_A_FIFOCTL   6'h00
`define MFH_A_BUILD     6'h04
`define MFH_A_SRST      6'h08
`define MFH_A_SALO      6'h0C
`define MFH_A_SAHI      6'h10
`define MFH_A_GTLO      6'h14
`define MFH_A_GTHI      6'h18
// -----------------------------------------------------------------
// Reset values and fixed fields
// -----------------------------------------------------------------
`define MFH_RX_LVL_RST  7'h02
`define MFH_TX_LVL_RST  5'h18
`define MFH_TX_DEPTH    8'h18
`define MFH_RX_DEPTH    8'h44
`define MFH_ADDR_KIND   8'h02
`define MFH_BUILD_VAL   8'h03
`define MFH_HASH_W      6
`define MFH_HASH_SLICES 8
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define MFH_RXLVL_HI    22
`define MFH_RXLVL_LO    16
`define MFH_TXLVL_HI    4
`define MFH_TXLVL_LO    0
`define MFH_SRST_BIT    0
`endif

/* File: src/mfh_pkg.sv */
// Types shared by the register slice.
// Assumes the constants header is included before use.
package mfh_pkg;
    // Bus request bundle
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } mfh_req_t;
    // Soft reset sequencer states
    typedef enum logic [2:0] {
        MFH_IDLE  = 3'b001,
        MFH_WAIT  = 3'b010,
        MFH_PULSE = 3'b100
    } mfh_srst_t;
endpackage

/* File: src/mfh_regs.sv */
// Register slice of the MAC: FIFO thresholds, build info, deferred
// soft reset, station address and group hash filter.
// Assumes Avalon-MM master on clock; FIFO/DMA status synchronous.
`timescale 1ns/1ps
`include "mfh_consts.svh"
module mfh_regs
    import mfh_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rx_flow_en,
    input  wire logic [7:0]  rx_fifo_cells,
    input  wire logic [7:0]  tx_fifo_cells,
    input  wire logic        tx_pkt_whole,
    input  wire logic        rx_dma_idle,
    input  wire logic        tx_dma_idle,
    input  wire logic        grp_valid,
    input  wire logic [47:0] dest_addr,
    output logic             rx_flow_trig,
    output logic             tx_start_ok,
    output logic             mac_logic_reset,
    output logic             grp_accept,
    output logic [47:0]      station_addr
);
    // -------------------------------------------------------------
    // Reset synchroniser
    // -------------------------------------------------------------
    logic       rst_s1_r;   // First stage, read only by second
    logic       rst_n_r;    // Design-wide reset copy

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // -------------------------------------------------------------
    // Bus request capture
    // -------------------------------------------------------------
    mfh_req_t   req;        // Bundled request
    logic       ack_r;      // Answer cycle marker
    logic       take;       // Request taken this edge

    assign req  = '{rd: avs_read, wr: avs_write, addr: avs_address,
                    wdata: avs_writedata};
    // Waitrequest drops for one cycle after every request is seen,
    // giving one wait state so read data can come from a flop.
    assign take = (req.rd | req.wr) & ack_r;

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (req.rd | req.wr) & ~ack_r;
        end
    end

    // Waitrequest from a flop: high except in the answer cycle
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((req.rd | req.wr) & ~ack_r);
        end
    end

    // -------------------------------------------------------------
    // Software registers
    // -------------------------------------------------------------
    logic [6:0]  rx_flow_cell_level_r;  // Rx flow control level
    logic [4:0]  tx_start_cell_level_r; // Tx start level
    logic [31:0] group_table_low_r;     // Hash values 0..31
    logic [31:0] group_table_high_r;    // Hash values 32..63
    logic        wr_hit;                // Write taken this edge

    assign wr_hit = take & req.wr;

    // FIFO control register
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_flow_cell_level_r  <= `MFH_RX_LVL_RST;
            tx_start_cell_level_r <= `MFH_TX_LVL_RST;
        end else if (wr_hit && req.addr == `MFH_A_FIFOCTL) begin
            rx_flow_cell_level_r  <=
                req.wdata[`MFH_RXLVL_HI:`MFH_RXLVL_LO];
            // Range 2..24 left to software; not clamped here
            tx_start_cell_level_r <=
                req.wdata[`MFH_TXLVL_HI:`MFH_TXLVL_LO];
        end
    end

    // Station address: byte n is address bits 8n+7..8n
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            station_addr <= 48'h0000_0000_0000;
        end else if (wr_hit && req.addr == `MFH_A_SALO) begin
            station_addr[7:0]  <= req.wdata[15:8];
            station_addr[15:8] <= req.wdata[7:0];
        end else if (wr_hit && req.addr == `MFH_A_SAHI) begin
            station_addr[23:16] <= req.wdata[31:24];
            station_addr[31:24] <= req.wdata[23:16];
            station_addr[39:32] <= req.wdata[15:8];
            station_addr[47:40] <= req.wdata[7:0];
        end
    end

    // Group hash table halves
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            group_table_low_r  <= 32'h0000_0000;
            group_table_high_r <= 32'h0000_0000;
        end else if (wr_hit && req.addr == `MFH_A_GTLO) begin
            group_table_low_r  <= req.wdata;
        end else if (wr_hit && req.addr == `MFH_A_GTHI) begin
            group_table_high_r <= req.wdata;
        end
    end

    // -------------------------------------------------------------
    // Deferred soft reset
    // -------------------------------------------------------------
    mfh_srst_t  srst_r;     // Sequencer state
    logic       srst_req;   // Software asks for reset

    assign srst_req = wr_hit && req.addr == `MFH_A_SRST &&
                      req.wdata[`MFH_SRST_BIT];

    // Reset is held off until both DMA engines sit idle, because
    // cutting them mid-transfer could hang the configuration bus.
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            srst_r <= MFH_IDLE;
        end else begin
            case (srst_r)
                MFH_IDLE: begin
                    if (srst_req) begin
                        srst_r <= MFH_WAIT;
                    end
                end
                MFH_WAIT: begin
                    if (rx_dma_idle && tx_dma_idle) begin
                        srst_r <= MFH_PULSE;
                    end
                end
                MFH_PULSE: begin
                    srst_r <= MFH_IDLE;
                end
                default: begin
                    srst_r <= MFH_IDLE;
                end
            endcase
        end
    end

    // One-cycle MAC reset pulse, from a flop
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            mac_logic_reset <= 1'b0;
        end else begin
            mac_logic_reset <= (srst_r == MFH_WAIT) &&
                               rx_dma_idle && tx_dma_idle;
        end
    end

    // -------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------
    logic [31:0] rd_nxt;    // Selected read word

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (req.addr)
            `MFH_A_FIFOCTL: rd_nxt = {9'h000, rx_flow_cell_level_r,
                                      11'h000, tx_start_cell_level_r};
            `MFH_A_BUILD:   rd_nxt = {`MFH_TX_DEPTH, `MFH_RX_DEPTH,
                                      `MFH_ADDR_KIND,
                                      `MFH_BUILD_VAL};
            // Pending reads one until the pulse has gone
            `MFH_A_SRST:    rd_nxt = {31'h0000_0000,
                                      srst_r != MFH_IDLE};
            `MFH_A_SALO:    rd_nxt = {16'h0000, station_addr[7:0],
                                      station_addr[15:8]};
            `MFH_A_SAHI:    rd_nxt = {station_addr[23:16],
                                      station_addr[31:24],
                                      station_addr[39:32],
                                      station_addr[47:40]};
            `MFH_A_GTLO:    rd_nxt = group_table_low_r;
            `MFH_A_GTHI:    rd_nxt = group_table_high_r;
            default:        rd_nxt = 32'h0000_0000; // Unmapped reads 0
        endcase
    end

    // Read data latched in the wait cycle, stands in answer cycle
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            avs_readdata <= 32'h0000_0000;
        end else if (req.rd && !ack_r) begin
            avs_readdata <= rd_nxt;
        end
    end

    // -------------------------------------------------------------
    // FIFO threshold decisions
    // -------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_flow_trig <= 1'b0;
            tx_start_ok  <= 1'b0;
        end else begin
            rx_flow_trig <= rx_flow_en &&
                (rx_fifo_cells >= {1'b0, rx_flow_cell_level_r});
            tx_start_ok  <= tx_pkt_whole ||
                (tx_fifo_cells >= {3'h0, tx_start_cell_level_r});
        end
    end

    // -------------------------------------------------------------
    // Group address hash filter
    // -------------------------------------------------------------
    logic [`MFH_HASH_W-1:0] hash;   // Folded address
    logic [63:0]            table_all;

    // XOR-fold eight 6-bit slices of the address
    always_comb begin
        hash = '0;
        for (int k = 0; k < `MFH_HASH_SLICES; k++) begin
            hash = hash ^ dest_addr[k*`MFH_HASH_W +: `MFH_HASH_W];
        end
    end
    assign table_all = {group_table_high_r, group_table_low_r};

    always_ff @(posedge clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            grp_accept <= 1'b0;
        end else begin
            grp_accept <= grp_valid && table_all[hash];
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    property p_srst_wait;
        @(posedge clock) disable iff (!rst_n_r)
        (srst_r == MFH_WAIT && !(rx_dma_idle && tx_dma_idle))
            |=> !mac_logic_reset;
    endproperty
    a_srst_wait: assert property (p_srst_wait)
        else $error("soft reset fired while DMA busy");

    property p_srst_done;
        @(posedge clock) disable iff (!rst_n_r)
        $rose(mac_logic_reset) |=> srst_r == MFH_IDLE;
    endproperty
    a_srst_done: assert property (p_srst_done)
        else $error("soft reset bit not cleared");

    property p_tx_start;
        @(posedge clock) disable iff (!rst_n_r)
        (!tx_pkt_whole && tx_fifo_cells < {3'h0, tx_start_cell_level_r})
            |=> !tx_start_ok;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("transmit started below level");

    // With flow enabled, occupancy at or above the level must raise the trigger
    property p_rx_flow;
        @(posedge clock) disable iff (!rst_n_r)
        (rx_flow_en && rx_fifo_cells >= {1'b0, rx_flow_cell_level_r})
            |=> rx_flow_trig;
    endproperty
    a_rx_flow: assert property (p_rx_flow)
        else $error("rx flow not triggered at level");

    // A wholly buffered packet may always start
    property p_tx_whole;
        @(posedge clock) disable iff (!rst_n_r)
        tx_pkt_whole |=> tx_start_ok;
    endproperty
    a_tx_whole: assert property (p_tx_whole)
        else $error("whole packet not started");

    // Verdict follows the table bit the hash selects
    property p_grp_hit;
        @(posedge clock) disable iff (!rst_n_r)
        grp_valid |=> grp_accept == $past(table_all[hash]);
    endproperty
    a_grp_hit: assert property (p_grp_hit)
        else $error("group verdict differs from table bit");

    // Build word is fixed whenever it is answered
    property p_build_rd;
        @(posedge clock) disable iff (!rst_n_r)
        (avs_read && !avs_waitrequest && avs_address == `MFH_A_BUILD)
            |-> avs_readdata == {`MFH_TX_DEPTH, `MFH_RX_DEPTH,
                                 `MFH_ADDR_KIND, `MFH_BUILD_VAL};
    endproperty
    a_build_rd: assert property (p_build_rd)
        else $error("build word read wrong");

    // MAC reset is a single-cycle pulse
    property p_srst_pulse;
        @(posedge clock) disable iff (!rst_n_r)
        mac_logic_reset |=> !mac_logic_reset;
    endproperty
    a_srst_pulse: assert property (p_srst_pulse)
        else $error("mac reset pulse longer than one cycle");
endmodule

/* File: verification/tb_mfh_regs.sv */
// Self-checking bench for the FIFO threshold, soft reset, station
// address and group hash register slice.
// Assumes the constants header and package compile first.
`timescale 1ns/1ps
`include "mfh_consts.svh"
module tb_mfh_regs
    import mfh_pkg::*;
;
// ---------------------------------------------------------------
// Stimulus and observed signals
// ---------------------------------------------------------------
logic        clock;            // 50 MHz system clock
logic        resetn;           // Async reset, active low
logic [5:0]  avs_address;      // Bus byte address
logic        avs_read;         // Bus read request
logic        avs_write;        // Bus write request
logic [31:0] avs_writedata;    // Bus write data
logic [31:0] avs_readdata;     // Bus read data
logic        avs_waitrequest;  // Bus stall
logic        rx_flow_en;       // Rx flow enable level
logic [7:0]  rx_fifo_cells;    // Rx occupancy
logic [7:0]  tx_fifo_cells;    // Tx occupancy
logic        tx_pkt_whole;     // Whole packet buffered
logic        rx_dma_idle;      // Rx DMA idle
logic        tx_dma_idle;      // Tx DMA idle
logic        grp_valid;        // Group address to test
logic [47:0] dest_addr;        // Destination address
logic        rx_flow_trig;     // Flow trigger out
logic        tx_start_ok;      // Transmit may start
logic        mac_logic_reset;  // Soft reset pulse
logic        grp_accept;       // Hash filter verdict
logic [47:0] station_addr;     // Station address out
int          fails;            // Mismatch count
int          cmp_count;        // Comparison count
logic [31:0] rd_val;           // Last bus read value

mfh_regs u_dut (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_flow_en(rx_flow_en), .rx_fifo_cells(rx_fifo_cells),
    .tx_fifo_cells(tx_fifo_cells), .tx_pkt_whole(tx_pkt_whole),
    .rx_dma_idle(rx_dma_idle), .tx_dma_idle(tx_dma_idle),
    .grp_valid(grp_valid), .dest_addr(dest_addr),
    .rx_flow_trig(rx_flow_trig), .tx_start_ok(tx_start_ok),
    .mac_logic_reset(mac_logic_reset), .grp_accept(grp_accept),
    .station_addr(station_addr));

// ---------------------------------------------------------------
// Clock, compare and bus helpers
// ---------------------------------------------------------------
// Free-running clock, 20 ns period
initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
end

// Multi-bit compare, case equality so X never matches
task automatic chk_val(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
    cmp_count++;
    if (g !== e) begin
        fails++;
        $display("BAD %s expected %h seen %h", nm, e, g);
    end
endtask

// Single flag compare
task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
        fails++;
        $display("BAD %s expected %b seen %b", nm, e, g);
    end
endtask

// Hold request until waitrequest sampled low; bounded wait
task automatic bus_xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~w;
    avs_write     <= w;
    do begin
        @(posedge clock);
        n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
        fails++;
        $display("BAD waitrequest expected 0 seen %b", avs_waitrequest);
    end
    rd_val    = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
endtask

// Read one register and compare the whole word
task automatic rd_chk(input string nm, input logic [5:0] a,
                      input logic [31:0] e);
    bus_xfer(1'b0, a, 32'h0000_0000);
    chk_val(nm, {16'h0000, e}, {16'h0000, rd_val});
endtask

// Bench's own six-bit fold of the destination address
function automatic logic [5:0] fold6(input logic [47:0] a);
    fold6 = 6'h00;
    for (int j = 0; j < 8; j++) begin
        fold6 = fold6 ^ a[6*j +: 6];
    end
endfunction

// ---------------------------------------------------------------
// Scenarios
// ---------------------------------------------------------------
// Reset contents, read-only build word, unmapped place
task automatic t_reset_vals;
    rd_chk("fifo_threshold_control", `MFH_A_FIFOCTL, 32'h0002_0018);
    rd_chk("mac_build_config", `MFH_A_BUILD, 32'h1844_0203);
    bus_xfer(1'b1, `MFH_A_BUILD, 32'h0000_0000);
    rd_chk("mac_build_config", `MFH_A_BUILD, 32'h1844_0203);
    rd_chk("logic_soft_reset", `MFH_A_SRST, 32'h0000_0000);
    bus_xfer(1'b1, 6'h3C, 32'hFFFF_FFFF);
    rd_chk("unmapped", 6'h3C, 32'h0000_0000);
endtask

// Rx trigger exactly at the level, Tx start by count or whole packet
task automatic t_levels;
    bus_xfer(1'b1, `MFH_A_FIFOCTL, 32'hFFFF_FFFF);
    rd_chk("fifo_threshold_control", `MFH_A_FIFOCTL, 32'h007F_001F);
    bus_xfer(1'b1, `MFH_A_FIFOCTL, 32'h0005_0003);
    for (int c = 4; c < 7; c++) begin
        rx_flow_en    <= 1'b1;
        rx_fifo_cells <= 8'(c);
        tx_fifo_cells <= 8'(c - 2);
        repeat (3) @(posedge clock);
        chk_bit("rx_flow_trig", c >= 5, rx_flow_trig);
        chk_bit("tx_start_ok", c >= 5, tx_start_ok);
    end
    rx_flow_en    <= 1'b0;
    tx_fifo_cells <= 8'h01;
    tx_pkt_whole  <= 1'b1;
    repeat (3) @(posedge clock);
    chk_bit("rx_flow_trig", 1'b0, rx_flow_trig);
    chk_bit("tx_start_ok", 1'b1, tx_start_ok);
    tx_pkt_whole <= 1'b0;
endtask

// Station address byte placement in both registers
task automatic t_station;
    bus_xfer(1'b1, `MFH_A_SALO, 32'hFFFF_A1B2);
    rd_chk("station_addr_low", `MFH_A_SALO, 32'h0000_A1B2);
    bus_xfer(1'b1, `MFH_A_SAHI, 32'hC3D4_E5F6);
    rd_chk("station_addr_high", `MFH_A_SAHI, 32'hC3D4_E5F6);
    repeat (2) @(posedge clock);
    chk_val("station_addr", 48'hF6E5_D4C3_B2A1,
            station_addr);
endtask

// Group filter over both table halves, then with no frame
task automatic t_hash;
    logic [63:0] tbl;
    logic [47:0] da;
    tbl = 64'h0F0F_0F0F_5555_5555;
    bus_xfer(1'b1, `MFH_A_GTLO, tbl[31:0]);
    bus_xfer(1'b1, `MFH_A_GTHI, tbl[63:32]);
    for (int k = 0; k < 16; k++) begin
        da = 48'h0123_4567_89AB * 48'(k + 1) + 48'(k);
        grp_valid <= 1'b1;
        dest_addr <= da;
        repeat (3) @(posedge clock);
        chk_bit("grp_accept", tbl[fold6(da)],
                grp_accept);
    end
    // Hand-folded: bits 47 and 2 give 36, table bit clear
    dest_addr <= 48'h8000_0000_0004;
    repeat (3) @(posedge clock);
    chk_bit("grp_accept", 1'b0, grp_accept);
    // Bits 6 and 0 cancel to hash 0, table bit set
    dest_addr <= 48'h0000_0000_0041;
    repeat (3) @(posedge clock);
    chk_bit("grp_accept", 1'b1, grp_accept);
    grp_valid <= 1'b0;
    repeat (3) @(posedge clock);
    chk_bit("grp_accept", 1'b0, grp_accept);
endtask

// Deferred soft reset: pending while a DMA is busy, then one pulse
task automatic t_soft_reset;
    int n;
    logic seen;
    rx_dma_idle <= 1'b0;
    bus_xfer(1'b1, `MFH_A_SRST, 32'h0000_0001);
    seen = 1'b0;
    for (n = 0; n < 10; n++) begin
        @(posedge clock);
        seen = seen | (mac_logic_reset === 1'b1);
    end
    chk_bit("mac_logic_reset", 1'b0, seen);
    rd_chk("logic_soft_reset", `MFH_A_SRST, 32'h0000_0001);
    rx_dma_idle <= 1'b1;
    n = 0;
    do begin
        @(posedge clock);
        n++;
    end while (mac_logic_reset !== 1'b1 && n < 20);
    chk_bit("mac_logic_reset", 1'b1, mac_logic_reset);
    rd_chk("logic_soft_reset", `MFH_A_SRST, 32'h0000_0000);
endtask

// ---------------------------------------------------------------
// Sequence, watchdog and verdict
// ---------------------------------------------------------------
// Print counts and the verdict, then stop
task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask

// Whole run needs under two hundred cycles; allow ample margin
initial begin
    #(20 * 20000);
    fails++;
    conclude();
end

// Main sequence; reset held for eight cycles
initial begin
    fails = 0;
    cmp_count = 0;
    resetn = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {rx_flow_en, rx_fifo_cells, tx_fifo_cells, tx_pkt_whole} = '0;
    {rx_dma_idle, tx_dma_idle, grp_valid, dest_addr} = {2'b11, 49'h0};
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset_vals();
    t_levels();
    t_station();
    t_hash();
    t_soft_reset();
    conclude();
end
endmodule
